// ### bench/tb.sv
// Purpose: Self-checking bench for xcr_router
// Assumes: External memory model on the multiplexed bus
// Notes:   Random moves around the range boundary in every setting
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin bad_count++; $display("MISMATCH t=%0t %s", $time, m); end end
module tb
    import xcr_pkg::*;
;
    logic        clk_i;
    logic        arst_n_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    xcr_req_t    req;
    xcr_resp_t   resp;
    xcr_onchip_t onc;
    logic        busy;
    logic        fext;
    logic        ext_pin;
    logic        rd_n;
    logic        wr_n;
    logic        ale;
    logic        dis_m;
    logic        vis_m;
    logic        sstb;
    logic        ssel;
    logic        e;
    logic [7:0]  ordata;
    logic [7:0]  lad_latch;
    logic [7:0]  hia_latch;
    logic [7:0]  lad_pin;
    logic [7:0]  lad_o;
    logic [7:0]  lad_oe;
    logic [7:0]  hia_o;
    logic [7:0]  hia_oe;
    logic [7:0]  mem_q;
    logic [15:0] sadr;
    logic [31:0] d;
    logic [7:0]  xm [0:65535];
    int          bad_count;
    int          comparisons;
    int          cnt;
    int          non;
    xcr_router uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .req_i(req), .resp_o(resp), .busy_o(busy), .fetch_external_o(fext),
        .onchip_o(onc), .onchip_rdata_i(ordata), .p0_latch_i(lad_latch), .p2_latch_i(hia_latch),
        .external_access_pin_i(ext_pin), .low_address_data_port_i(lad_pin),
        .low_address_data_port_o(lad_o), .low_address_data_port_oe_o(lad_oe),
        .high_address_port_o(hia_o), .high_address_port_oe_o(hia_oe), .rd_n_o(rd_n), .wr_n_o(wr_n), .ale_o(ale));
    xcr_ext_mem u_mem (.clk_i(clk_i), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n), .ad_i(lad_pin),
        .hi_i(hia_o), .ad_o(mem_q));
    assign lad_pin = (lad_oe & lad_o) | (~lad_oe & mem_q);
    initial
    begin
        clk_i = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        if (!rd_n || !wr_n)
            sstb = 1'b1;
        if (onc.sel)
        begin
            ssel = 1'b1;
            sadr = onc.addr;
        end
    end
    task automatic print_verdict;
        $display("Counts: %0d compared, %0d mismatched", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic lim(input int n);
        if (n >= 30)
        begin
            bad_count++;
            $display("MISMATCH t=%0t wait limit reached", $time);
            print_verdict();
        end
    endtask : lim
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 30);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        lim(n);
    endtask : apb
    task automatic mv(input logic w, input logic ind);
        logic [15:0] dp;
        logic [15:0] oa;
        logic [15:0] xa;
        logic [7:0]  pg;
        logic [7:0]  idx;
        logic [7:0]  hv;
        logic [7:0]  wd;
        logic [7:0]  ex;
        logic        on;
        logic        stb;
        int          n;
        dp = ONCHIP_LOW_ADDR + 16'($urandom_range(7)) - 16'h0004;
        if ($urandom_range(3) == 0)
            dp = 16'($urandom);
        pg = ONCHIP_LOW_PAGE - 8'($urandom_range(1));
        idx = 8'($urandom);
        hv = 8'($urandom);
        wd = 8'($urandom);
        on = !dis_m && (ind ? pg >= ONCHIP_LOW_PAGE : dp >= ONCHIP_LOW_ADDR);
        stb = !on || vis_m;
        non += on;
        oa = ind ? {pg, idx} : dp;
        xa = ind ? {hv, idx} : dp;
        ex = on ? oa[15:8] ^ oa[7:0] ^ 8'h3C : xm[xa];
        if (stb && w)
            xm[xa] = wd;
        @(posedge clk_i);
        req <= '{1'b1, w, ind, dp, pg, idx, wd};
        ordata <= oa[15:8] ^ oa[7:0] ^ 8'h3C;
        hia_latch <= hv;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (busy !== 1'b0 && n < 30);
        lim(n);
        sstb = 1'b0;
        ssel = 1'b0;
        req.valid <= 1'b0;
        n = 0;
        while (resp.done !== 1'b1 && n < 30)
        begin
            @(posedge clk_i);
            n++;
        end
        lim(n);
        `CHK(sstb, stb, "strobe activity")
        `CHK(ssel, on, "on-chip select")
        if (on)
            `CHK(sadr, oa, "on-chip address")
        if (!w)
            `CHK(resp.rdata, ex, "read data")
    endtask : mv
    initial
    begin
        bad_count = 0;
        comparisons = 0;
        arst_n_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        req = '0;
        ordata = 8'h00;
        lad_latch = 8'hFF;
        hia_latch = 8'h00;
        ext_pin = 1'b0;
        for (int a = 0; a < 65536; a++)
            xm[a] = 8'(a) ^ 8'hA5;
        void'($urandom(32'h01EC));
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        apb(1'b0, SYSCTL_OFFSET, 32'h0);
        `CHK(d[0], 1'b1, "disable bit after reset")
        apb(1'b0, 12'hFF0, 32'h0);
        `CHK(e, 1'b1, "unmapped address error")
        $display("reset test done");
        for (int ph = 0; ph < 6; ph++)
        begin
            dis_m = ph < 2;
            vis_m = ph == 1 || ph > 3;
            ext_pin <= ph[0];
            lad_latch <= 8'($urandom);
            apb(1'b1, SYSCTL_OFFSET, {30'h0, vis_m, dis_m});
            if (ph == 2)
            begin
                apb(1'b1, SYSCTL_OFFSET, 32'h1);
                apb(1'b0, SYSCTL_OFFSET, 32'h0);
                `CHK(d[1:0], 2'b00, "disable bit set again")
            end
            repeat (4) @(posedge clk_i);
            `CHK(fext, !ext_pin, "fetch source")
            `CHK(hia_oe, 8'hFF, "port 2 drive")
            for (int k = 0; k < 12; k++)
                mv(k[0], k[1]);
            $display("setting test %0d done", ph);
        end
        apb(1'b1, SYSCTL_OFFSET, 32'h4);
        for (int j = 0; j < 2; j++)
        begin
            ext_pin <= !j[0];
            repeat (4) @(posedge clk_i);
            cnt = 0;
            repeat (2 * ALE_PERIOD_OSC)
            begin
                @(posedge clk_i);
                cnt += ale;
            end
            `CHK(cnt, 2 * j, "address latch pulses")
        end
        apb(1'b0, ONCHIP_COUNT_OFFSET, 32'h0);
        `CHK(d[15:0], 16'(non), "on-chip move count")
        $display("latch strobe test done");
        print_verdict();
    end
endmodule : tb
bind xcr_router xcr_props #(.LOW_ADDR(LOW_ADDR), .LOW_PAGE(LOW_PAGE)) u_props (.clk_i, .arst_n_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .req_i, .resp_o, .busy_o, .fetch_external_o,
    .onchip_o, .external_access_pin_i, .low_address_data_port_oe_o, .high_address_port_o, .rd_n_o,
    .wr_n_o, .ale_o);
`default_nettype wire

// ### bench/xcr_ext_mem.sv
// Purpose: External parallel memory on the multiplexed bus
// Assumes: Low address latched while the latch strobe is high
// Notes:   Released data lines hold read data for two cycles, then toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module xcr_ext_mem
#(
    parameter int LAG = 0
)
(
    input  wire logic       clk_i,
    input  wire logic       ale_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic [7:0] ad_i,
    input  wire logic [7:0] hi_i,
    output logic      [7:0] ad_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] lo;
    int         lag;
    int         hold;
    initial
    begin
        for (int a = 0; a < 65536; a++)
            mem[a] = 8'(a) ^ 8'hA5;
        lo = 8'h00;
        lag = 0;
        hold = 0;
        ad_o = 8'h00;
    end
    always @(posedge clk_i)
    begin
        if (ale_i)
            lo <= ad_i;
        if (!wr_n_i)
            mem[{hi_i, lo}] <= ad_i;
        if (!rd_n_i && lag >= LAG)
        begin
            ad_o <= mem[{hi_i, lo}];
            hold <= 2;
        end
        else if (hold > 0)
            hold <= hold - 1;
        else
            ad_o <= ~ad_o;
        lag <= rd_n_i ? 0 : lag + 1;
    end
endmodule : xcr_ext_mem
`default_nettype wire

// ### bench/xcr_props.sv
// Purpose: Port-level assertions for xcr_router
// Assumes: Control bits are mirrored from APB writes
// Notes:   Bound to the router from tb
`timescale 1ns/1ps
`default_nettype none
module xcr_props
    import xcr_pkg::*;
#(
    parameter logic [15:0] LOW_ADDR = ONCHIP_LOW_ADDR,
    parameter logic [7:0]  LOW_PAGE = ONCHIP_LOW_PAGE
)
(
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire xcr_req_t    req_i,
    input wire xcr_resp_t   resp_o,
    input wire logic        busy_o,
    input wire logic        fetch_external_o,
    input wire xcr_onchip_t onchip_o,
    input wire logic        external_access_pin_i,
    input wire logic [7:0]  low_address_data_port_oe_o,
    input wire logic [7:0]  high_address_port_o,
    input wire logic        rd_n_o,
    input wire logic        wr_n_o,
    input wire logic        ale_o
);
    logic        dis;
    logic        vis;
    logic        alo;
    logic        acc;
    logic        onc;
    logic        lbus;
    logic [15:0] oad;
    logic [7:0]  dph;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    assign acc = req_i.valid && !busy_o;
    assign onc = !dis && (req_i.indirect ? req_i.external_page_register >= LOW_PAGE
                                         : req_i.data_pointer >= LOW_ADDR);
    assign lbus = !(onc && !vis && !fetch_external_o);
    assign oad = req_i.indirect ? {req_i.external_page_register, req_i.indirect_index_register}
                                : req_i.data_pointer;
    assign dph = req_i.data_pointer[15:8];
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            dis <= 1'b1;
            vis <= 1'b0;
            alo <= 1'b0;
        end
        else if (psel_i && penable_i && pwrite_i && paddr_i == SYSCTL_OFFSET)
        begin
            dis <= dis & pwdata_i[0];
            vis <= pwdata_i[1];
            alo <= pwdata_i[2];
        end
    end
    sequence s_rd_low3;
        !rd_n_o [*3] ##1 rd_n_o;
    endsequence
    sequence s_idle5;
        (!busy_o && !ale_o) [*5];
    endsequence
    a_done_latency: assert property (acc |-> ##6 resp_o.done)
        else $error("move did not finish on time");
    a_strobe_on: assert property (acc && (!onc || vis) |=> ##1 !(rd_n_o && wr_n_o))
        else $error("strobe missing");
    a_strobe_off: assert property (acc && onc && !vis |=> (rd_n_o && wr_n_o) [*6])
        else $error("strobe on hidden access");
    a_no_onchip: assert property (acc && dis |=> !onchip_o.sel [*6])
        else $error("on-chip select while disabled");
    a_onchip_hit: assert property (acc && onc |=> ##1 onchip_o.sel && onchip_o.addr == $past(oad, 2))
        else $error("on-chip select wrong");
    a_high_addr: assert property (acc && lbus && !req_i.indirect |=> high_address_port_o == $past(dph))
        else $error("high address wrong");
    a_low_bus: assert property (acc && lbus |=> ale_o && low_address_data_port_oe_o == 8'hFF)
        else $error("low port not driven as bus");
    a_rd_pulse: assert property ($fell(rd_n_o) |-> s_rd_low3)
        else $error("read strobe width wrong");
    a_ale_period: assert property ((ale_o && !busy_o) ##1 s_idle5 ##0 !(alo && !fetch_external_o)
        |=> ale_o || busy_o)
        else $error("address latch pulse missing");
    a_fetch_pin: assert property ($stable(external_access_pin_i) [*4] ##0 $past(arst_n_i, 2)
        |-> fetch_external_o == !external_access_pin_i)
        else $error("fetch source wrong");
    a_ctrl_read: assert property (psel_i && !pwrite_i && paddr_i == SYSCTL_OFFSET
        |-> prdata_o[2:0] == {alo, vis, dis})
        else $error("control read back wrong");
endmodule : xcr_props
`default_nettype wire

// ### hw/xcr_pkg.sv
// Purpose: Shared constants and carriers for the external data move router
// Assumes: One 10 MHz clock that stands for the oscillator, APB register access
// Notes:   Offsets, bit positions, reset values and cycle counts live here
package xcr_pkg;

    // Clock and timing
    localparam int          CLK_PERIOD_NS      = 100;
    localparam int          ALE_PERIOD_OSC     = 6;
    localparam logic [2:0]  ALE_PERIOD_CYC     = 3'(ALE_PERIOD_OSC);
    localparam int          STROBE_NS          = 300;
    localparam logic [3:0]  STROBE_CYC         = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Lower boundary of the on-chip area
    localparam logic [15:0] ONCHIP_LOW_ADDR    = 16'hF600;
    localparam logic [7:0]  ONCHIP_LOW_PAGE    = 8'hF6;

    // Register map (byte addresses)
    localparam logic [11:0] SYSCTL_OFFSET      = 12'h000;
    localparam logic [11:0] STATUS_OFFSET      = 12'h004;
    localparam logic [11:0] EXT_COUNT_OFFSET   = 12'h008;
    localparam logic [11:0] ONCHIP_COUNT_OFFSET = 12'h00C;

    // system_control fields
    localparam int          ON_CHIP_DATA_RAM_ACCESS_DISABLE_BIT = 0;
    localparam int          ON_CHIP_DATA_RAM_VISIBLE_ACCESS_BIT = 1;
    localparam int          ALE_OFF_BIT        = 2;
    localparam logic [7:0]  SYSCTL_RESET       = 8'h01;

    // status fields
    localparam int          STAT_EA_BIT        = 0;
    localparam int          STAT_FETCH_EXT_BIT = 1;
    localparam int          STAT_BUSY_BIT      = 2;
    localparam int          STAT_LAST_ONCHIP_BIT = 3;

    typedef enum logic [1:0] {
        XCR_IDLE   = 2'b00,
        XCR_ADDR   = 2'b01,
        XCR_STROBE = 2'b10,
        XCR_DONE   = 2'b11
    } xcr_state_t;

    // External data move request from the core
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        indirect;
        logic [15:0] data_pointer;
        logic [7:0]  external_page_register;
        logic [7:0]  indirect_index_register;
        logic [7:0]  wdata;
    } xcr_req_t;

    typedef struct packed {
        logic        done;
        logic [7:0]  rdata;
    } xcr_resp_t;

    // Access to on-chip RAM and CAN register area
    typedef struct packed {
        logic        sel;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } xcr_onchip_t;

    // Routing decision for one access
    typedef struct packed {
        logic        use_onchip;
        logic        p0_bus;
        logic        p2_bus;
        logic        strobe;
    } xcr_route_t;

endpackage : xcr_pkg

// ### hw/xcr_router.sv
// Contract
// - On-chip RAM sits at top of external data space, reached only by data moves.
// - CAN register and data bytes sit inside the external data address area.
// - Access-disable bit at 0 enables on-chip RAM and CAN accesses.
// - Access-disable resets to 1; then every data move uses the external bus.
// - Once cleared, access-disable cannot be set by software; only reset sets it.
// - Visible-access 0 keeps read and write strobes idle for on-chip hits.
// - Visible-access 1 drives ports 0 and 2 and strobes for on-chip hits.
// - Visible-access has no effect out of range or when access is disabled.
// - Pointer moves below range always use external memory, ports as bus, strobes on.
// - Indirect moves compare page register; port 0 bus, port 2 stays I/O.
// - Setting 00 in range: on-chip, strobes idle, ports bus only with pin low.
// - Setting 10 in range pointer move: on-chip, ports as bus, strobes active.
// - Setting X1 in range: external memory, ports bus, strobes active.
// - Address latch pulses every six oscillator periods, skipped during data moves.
// - Address latch may be switched off while executing from internal memory.
// - External-access pin high fetches internal ROM, low fetches external memory.
// - Protected variant captures external-access pin at reset and keeps it; the capture takes the synchroniser's reset value 1, so ea_held stays 1.
// - Port 0 multiplexes low address and data, driving ones strongly.
//
// Purpose: Routes external data moves to on-chip RAM/CAN or the multiplexed bus
// Assumes: clk_i is the oscillator; pins pass a two-stage synchroniser
// Notes:   APB slave answers with zero wait states
`timescale 1ns/1ps
`default_nettype none

module xcr_router
    import xcr_pkg::*;
#(
    parameter logic [15:0] LOW_ADDR      = ONCHIP_LOW_ADDR,
    parameter logic [7:0]  LOW_PAGE      = ONCHIP_LOW_PAGE,
    parameter bit          ROM_PROTECTED = 1'b0
)
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Core side
    input  wire xcr_req_t    req_i,
    output xcr_resp_t        resp_o,
    output logic             busy_o,
    output logic             fetch_external_o,
    // On-chip RAM and CAN area
    output xcr_onchip_t      onchip_o,
    input  wire logic [7:0]  onchip_rdata_i,
    // Port latches for general I/O use
    input  wire logic [7:0]  p0_latch_i,
    input  wire logic [7:0]  p2_latch_i,
    // Pins
    input  wire logic        external_access_pin_i,
    input  wire logic [7:0]  low_address_data_port_i,
    output logic      [7:0]  low_address_data_port_o,
    output logic      [7:0]  low_address_data_port_oe_o,
    output logic      [7:0]  high_address_port_o,
    output logic      [7:0]  high_address_port_oe_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic             ale_o
);

    logic [7:0]  system_control;
    logic [1:0]  ea_sync;
    logic        ea_held;
    logic        ea_captured;
    logic        ea_eff;
    logic [7:0]  p0_sync1;
    logic [7:0]  p0_sync2;
    logic [2:0]  ale_cnt;
    logic        ale_tick;
    xcr_state_t  state;
    logic [3:0]  phase_cnt;
    xcr_req_t    cur;
    xcr_route_t  cur_route;
    xcr_route_t  new_route;
    logic        last_onchip;
    logic [15:0] ext_count;
    logic [15:0] onchip_count;
    logic        apb_wr;
    logic        apb_rd_hit;
    logic [7:0]  next_ctrl;

    // Decides port, strobe and target use for one access
    function automatic xcr_route_t route_decode(
        input logic [7:0]  ctrl,
        input logic        ea,
        input xcr_req_t    r
    );
        xcr_route_t rt;
        logic       in_range;
        rt       = '0;
        in_range = r.indirect ? (r.external_page_register >= LOW_PAGE)
                              : (r.data_pointer >= LOW_ADDR);
        if (!in_range || ctrl[ON_CHIP_DATA_RAM_ACCESS_DISABLE_BIT])
        begin
            rt.use_onchip = 1'b0;
            rt.p0_bus     = 1'b1;
            rt.p2_bus     = ~r.indirect;
            rt.strobe     = 1'b1;
        end
        else if (ctrl[ON_CHIP_DATA_RAM_VISIBLE_ACCESS_BIT])
        begin
            rt.use_onchip = 1'b1;
            rt.p0_bus     = 1'b1;
            rt.p2_bus     = ~r.indirect;
            rt.strobe     = 1'b1;
        end
        else
        begin
            rt.use_onchip = 1'b1;
            rt.p0_bus     = ~ea;
            rt.p2_bus     = ~ea & ~r.indirect;
            rt.strobe     = 1'b0;
        end
        return rt;
    endfunction : route_decode

    // External-access pin synchroniser
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ea_sync <= 2'b11;
        else
            ea_sync <= {ea_sync[0], external_access_pin_i};
    end

    // Strap capture right after reset release
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ea_captured <= 1'b0;
            ea_held     <= 1'b1;
        end
        else if (!ea_captured)
        begin
            ea_captured <= 1'b1;
            ea_held     <= ea_sync[1];
        end
    end

    assign ea_eff           = ROM_PROTECTED ? ea_held : ea_sync[1];
    assign fetch_external_o = ~ea_eff;

    // Port 0 input synchroniser
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            p0_sync1 <= 8'h00;
            p0_sync2 <= 8'h00;
        end
        else
        begin
            p0_sync1 <= low_address_data_port_i;
            p0_sync2 <= p0_sync1;
        end
    end

    // APB register access
    assign pready_o   = 1'b1;
    assign apb_wr     = psel_i & penable_i & pwrite_i;
    assign apb_rd_hit = (paddr_i == SYSCTL_OFFSET) || (paddr_i == STATUS_OFFSET)
                     || (paddr_i == EXT_COUNT_OFFSET) || (paddr_i == ONCHIP_COUNT_OFFSET);
    assign pslverr_o  = psel_i & penable_i & ~apb_rd_hit;

    always_comb
    begin
        next_ctrl = system_control;
        next_ctrl[ON_CHIP_DATA_RAM_VISIBLE_ACCESS_BIT] = pwdata_i[ON_CHIP_DATA_RAM_VISIBLE_ACCESS_BIT];
        next_ctrl[ALE_OFF_BIT]             = pwdata_i[ALE_OFF_BIT];
        next_ctrl[ON_CHIP_DATA_RAM_ACCESS_DISABLE_BIT] = system_control[ON_CHIP_DATA_RAM_ACCESS_DISABLE_BIT]
                                           & pwdata_i[ON_CHIP_DATA_RAM_ACCESS_DISABLE_BIT];
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            system_control <= SYSCTL_RESET;
        else if (apb_wr && paddr_i == SYSCTL_OFFSET)
            system_control <= next_ctrl;
    end

    always_comb
    begin
        prdata_o = 32'h0000_0000;
        case (paddr_i)
            SYSCTL_OFFSET:
                prdata_o = {24'h00_0000, 5'h00, system_control[2:0]};
            STATUS_OFFSET:
            begin
                prdata_o[STAT_EA_BIT]          = ea_eff;
                prdata_o[STAT_FETCH_EXT_BIT]   = ~ea_eff;
                prdata_o[STAT_BUSY_BIT]        = busy_o;
                prdata_o[STAT_LAST_ONCHIP_BIT] = last_onchip;
            end
            EXT_COUNT_OFFSET:
                prdata_o = {16'h0000, ext_count};
            ONCHIP_COUNT_OFFSET:
                prdata_o = {16'h0000, onchip_count};
            default:
                prdata_o = 32'h0000_0000;
        endcase
    end

    // Address latch rhythm
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ale_cnt <= 3'h0;
        else if (ale_cnt == ALE_PERIOD_CYC - 3'h1)
            ale_cnt <= 3'h0;
        else
            ale_cnt <= ale_cnt + 3'h1;
    end

    assign ale_tick = (ale_cnt == 3'h0);

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ale_o <= 1'b0;
        else if (state == XCR_IDLE && req_i.valid)
            ale_o <= new_route.p0_bus;
        else if (state != XCR_IDLE)
            ale_o <= 1'b0;
        else if (system_control[ALE_OFF_BIT] && ea_eff)
            ale_o <= 1'b0;
        else
            ale_o <= ale_tick;
    end

    // Data move sequencer
    assign new_route = route_decode(system_control, ea_eff, req_i);
    assign busy_o    = (state != XCR_IDLE);

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state     <= XCR_IDLE;
            phase_cnt <= 4'h0;
        end
        else
        begin
            case (state)
                XCR_IDLE:
                    if (req_i.valid)
                        state <= XCR_ADDR;
                XCR_ADDR:
                begin
                    state     <= XCR_STROBE;
                    phase_cnt <= STROBE_CYC - 4'h1;
                end
                XCR_STROBE:
                    if (phase_cnt == 4'h0)
                        state <= XCR_DONE;
                    else
                        phase_cnt <= phase_cnt - 4'h1;
                XCR_DONE:
                    state <= XCR_IDLE;
                default:
                    state <= XCR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cur       <= '0;
            cur_route <= '0;
        end
        else if (state == XCR_IDLE && req_i.valid)
        begin
            cur       <= req_i;
            cur_route <= new_route;
        end
    end

    // Access statistics and last target
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ext_count    <= 16'h0000;
            onchip_count <= 16'h0000;
            last_onchip  <= 1'b0;
        end
        else if (state == XCR_DONE)
        begin
            last_onchip <= cur_route.use_onchip;
            if (cur_route.use_onchip)
                onchip_count <= onchip_count + 16'h0001;
            else
                ext_count <= ext_count + 16'h0001;
        end
    end

    // On-chip target strobe, one cycle in the first strobe phase
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            onchip_o <= '0;
        else
        begin
            onchip_o.sel   <= (state == XCR_ADDR) && cur_route.use_onchip;
            onchip_o.write <= cur.write;
            onchip_o.addr  <= cur.indirect ? {cur.external_page_register, cur.indirect_index_register}
                                           : cur.data_pointer;
            onchip_o.wdata <= cur.wdata;
        end
    end

    // Read data and completion
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            resp_o <= '0;
        else
        begin
            resp_o.done <= (state == XCR_DONE);
            if (state == XCR_DONE && !cur.write)
                resp_o.rdata <= cur_route.use_onchip ? onchip_rdata_i : p0_sync2;
        end
    end

    // Strobes
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
        end
        else
        begin
            rd_n_o <= ~((state == XCR_ADDR || (state == XCR_STROBE && phase_cnt != 4'h0))
                        && cur_route.strobe && !cur.write);
            wr_n_o <= ~((state == XCR_ADDR || (state == XCR_STROBE && phase_cnt != 4'h0))
                        && cur_route.strobe && cur.write);
        end
    end

    // Port drive
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            low_address_data_port_o    <= 8'h00;
            low_address_data_port_oe_o <= 8'h00;
            high_address_port_o        <= 8'h00;
            high_address_port_oe_o     <= 8'h00;
        end
        else
        begin
            low_address_data_port_o    <= 8'h00;
            low_address_data_port_oe_o <= ~p0_latch_i;
            high_address_port_o        <= p2_latch_i;
            high_address_port_oe_o     <= 8'hFF;
            if (state == XCR_IDLE && req_i.valid && new_route.p0_bus)
            begin
                low_address_data_port_o    <= req_i.indirect ? req_i.indirect_index_register
                                                             : req_i.data_pointer[7:0];
                low_address_data_port_oe_o <= 8'hFF;
            end
            else if ((state == XCR_ADDR || state == XCR_STROBE) && cur_route.p0_bus)
            begin
                low_address_data_port_o    <= cur.write ? cur.wdata : onchip_rdata_i;
                low_address_data_port_oe_o <= (cur.write || cur_route.use_onchip) ? 8'hFF : 8'h00;
            end
            if (state == XCR_IDLE && req_i.valid && new_route.p2_bus)
                high_address_port_o <= req_i.data_pointer[15:8];
            else if (state != XCR_IDLE && state != XCR_DONE && cur_route.p2_bus)
                high_address_port_o <= cur.data_pointer[15:8];
        end
    end

endmodule : xcr_router

`default_nettype wire
